// ==== doz_pkg.sv ====
// Operation
// RL1: register form is primary opcode 31 with extended opcode 264; bit 21 overflow, 31 record
// RL2: immediate form is primary opcode 09; target, source and signed immediate fields
// RL3: register form writes complement of first source plus one plus second source
// RL4: register form writes zero when first source is signed-greater than second
// RL5: immediate form writes complement of source plus sign-extended immediate plus one
// RL6: immediate form writes zero when source is signed-greater than the immediate
// RL7: immediate form leaves condition field and every exception bit untouched
// RL8: overflow option updates overflow and summary bits; overflow only on positive overflow
// RL9: register form never changes the carry bit
// RL10: record option updates less, greater, equal and summary bits of condition field
// RL11: condition sign bits compare result with zero; summary bit copied after update
// RL12: summary overflow is sticky until software clears it explicitly
package doz_pkg;
	localparam int DATA_W = 32;
	localparam int IDX_W = 5;
	localparam int IMM_W = 16;
	localparam int XO_W = 9;
	localparam int OPC_W = 6;

	// big-endian bit k of the instruction sits at index 31-k
	localparam int OPC_HI = 31;
	localparam int OPC_LO = 26;
	localparam int RT_HI = 25;
	localparam int RT_LO = 21;
	localparam int RA_HI = 20;
	localparam int RA_LO = 16;
	localparam int RB_HI = 15;
	localparam int RB_LO = 11;
	localparam int OE_POS = 10;
	localparam int XO_HI = 9;
	localparam int XO_LO = 1;
	localparam int RC_POS = 0;
	localparam int SI_HI = 15;
	localparam int SI_LO = 0;

	localparam logic [OPC_W-1:0] OPC_REG_FORM = 6'h1f;
	localparam logic [XO_W-1:0] XO_DOZ = 9'h108;
	localparam logic [OPC_W-1:0] OPC_IMM_FORM = 6'h09;

	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_EXC = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_COND = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_RESULT = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_OP_COUNT = 8'h14;

	localparam int EXC_SO_BIT = 31;
	localparam int EXC_OV_BIT = 30;
	localparam int EXC_CA_BIT = 29;

	// condition field 0 as {less, greater, equal, summary}
	localparam int COND_W = 4;
	localparam int COND_LT_BIT = 3;
	localparam int COND_GT_BIT = 2;
	localparam int COND_EQ_BIT = 1;
	localparam int COND_SO_BIT = 0;

	localparam int INT_W = 3;
	localparam int INT_OVF_BIT = 0;
	localparam int INT_ILLEGAL_BIT = 1;
	localparam int INT_ZEROED_BIT = 2;

	localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0;
	localparam logic [COND_W-1:0] COND_RESET = 4'h0;
	localparam logic [INT_W-1:0] INT_RESET = 3'h0;

	typedef struct packed {
		logic is_reg;
		logic is_imm;
		logic illegal;
		logic overflow_enable;
		logic record_option;
		logic [IDX_W-1:0] target_reg_index;
		logic [DATA_W-1:0] first_operand;
		logic [DATA_W-1:0] second_operand;
	} decode_t;

	typedef struct packed {
		logic [DATA_W-1:0] value;
		logic overflow;
		logic zeroed;
	} exec_t;

	function automatic logic [DATA_W-1:0] exc_pack(input logic so,
		input logic ov, input logic ca);
		logic [DATA_W-1:0] w;
		w = WORD_ZERO;
		w[EXC_SO_BIT] = so;
		w[EXC_OV_BIT] = ov;
		w[EXC_CA_BIT] = ca;
		return w;
	endfunction
endpackage

// ==== instr_field_decoder.sv ====
`timescale 1ns/10ps
module instr_field_decoder (
	input wire logic [doz_pkg::DATA_W-1:0] instr,
	input wire logic [doz_pkg::DATA_W-1:0] first_src_data,
	input wire logic [doz_pkg::DATA_W-1:0] second_src_data,
	output doz_pkg::decode_t dec
);
	import doz_pkg::*;

	wire logic [OPC_W-1:0] opcode = instr[OPC_HI:OPC_LO];
	wire logic [XO_W-1:0] ext_opcode = instr[XO_HI:XO_LO];
	wire logic [IMM_W-1:0] imm = instr[SI_HI:SI_LO];
	wire logic [DATA_W-1:0] imm_ext = {{(DATA_W-IMM_W){imm[IMM_W-1]}}, imm};
	wire logic reg_form = (opcode == OPC_REG_FORM) &&
		(ext_opcode == XO_DOZ); // RL1
	wire logic imm_form = (opcode == OPC_IMM_FORM); // RL2

	assign dec.is_reg = reg_form;
	assign dec.is_imm = imm_form;
	assign dec.illegal = !(reg_form || imm_form);
	// immediate form carries no option bits
	assign dec.overflow_enable = reg_form && instr[OE_POS]; // RL1 RL7
	assign dec.record_option = reg_form && instr[RC_POS]; // RL1 RL7
	assign dec.target_reg_index = instr[RT_HI:RT_LO]; // RL2
	assign dec.first_operand = first_src_data;
	assign dec.second_operand = imm_form ? imm_ext : second_src_data; // RL2
endmodule

// ==== diff_or_zero_unit.sv ====
`timescale 1ns/10ps
module diff_or_zero_unit (
	input wire logic [doz_pkg::DATA_W-1:0] first_operand,
	input wire logic [doz_pkg::DATA_W-1:0] second_operand,
	output doz_pkg::exec_t res
);
	import doz_pkg::*;

	// one guard bit so positive overflow is visible in the sum
	function automatic logic [DATA_W:0] widen(input logic [DATA_W-1:0] v);
		return {v[DATA_W-1], v};
	endfunction

	wire logic [DATA_W:0] one_wide = {{DATA_W{1'b0}}, 1'b1};
	wire logic [DATA_W:0] sum = ~widen(first_operand) +
		widen(second_operand) + one_wide; // RL3 RL5
	wire logic greater = $signed(first_operand) >
		$signed(second_operand); // RL4 RL6
	wire logic pos_overflow = !sum[DATA_W] && sum[DATA_W-1];

	assign res.value = greater ? WORD_ZERO : sum[DATA_W-1:0]; // RL4 RL6
	assign res.overflow = !greater && pos_overflow; // RL8
	assign res.zeroed = greater;
endmodule

// ==== difference_or_zero_alu.sv ====
`timescale 1ns/10ps
module difference_or_zero_alu #(
	parameter int COUNT_W = 32
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic ISSUE_VALID,
	input wire logic [doz_pkg::DATA_W-1:0] ISSUE_INSTR,
	input wire logic [doz_pkg::DATA_W-1:0] FIRST_SRC_DATA,
	input wire logic [doz_pkg::DATA_W-1:0] SECOND_SRC_DATA,
	output logic WB_VALID,
	output logic [doz_pkg::IDX_W-1:0] WB_INDEX,
	output logic [doz_pkg::DATA_W-1:0] WB_DATA,
	output logic SUMMARY_OVERFLOW,
	output logic OVERFLOW,
	output logic CARRY,
	output logic [doz_pkg::COND_W-1:0] COND_FIELD0,
	input wire logic [doz_pkg::ADDR_W-1:0] REG_ADDR,
	input wire logic [doz_pkg::DATA_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [doz_pkg::DATA_W-1:0] REG_RDATA,
	output logic IRQ
);
	import doz_pkg::*;

	if (COUNT_W < 1 || COUNT_W > DATA_W) begin : g_check
		$error("COUNT_W must lie between 1 and the data width");
	end

	decode_t dec;
	exec_t res;

	instr_field_decoder u_decode (
		.instr(ISSUE_INSTR),
		.first_src_data(FIRST_SRC_DATA),
		.second_src_data(SECOND_SRC_DATA),
		.dec(dec)
	);

	diff_or_zero_unit u_exec (
		.first_operand(dec.first_operand),
		.second_operand(dec.second_operand),
		.res(res)
	);

	logic so;
	logic ov;
	logic ca;
	logic [COND_W-1:0] cond;
	logic [DATA_W-1:0] last_result;
	logic [INT_W-1:0] int_status;
	logic [INT_W-1:0] int_mask;
	logic [COUNT_W-1:0] op_count;

	// issue side
	wire logic executes = ISSUE_VALID && !dec.illegal;
	wire logic ov_update = ISSUE_VALID && dec.overflow_enable; // RL8 RL7
	wire logic cond_update = ISSUE_VALID && dec.record_option; // RL10 RL7
	wire logic so_set = ov_update && res.overflow; // RL8 RL12

	// register bus decode
	wire logic wr_exc = REG_WR && (REG_ADDR == ADDR_EXC);
	wire logic wr_cond = REG_WR && (REG_ADDR == ADDR_COND);
	wire logic wr_int_status = REG_WR && (REG_ADDR == ADDR_INT_STATUS);
	wire logic wr_int_mask = REG_WR && (REG_ADDR == ADDR_INT_MASK);

	// software may clear the summary bit, but a same-cycle overflow wins
	wire logic sw_so = wr_exc ? REG_WDATA[EXC_SO_BIT] : so;
	wire logic next_so = so_set || sw_so; // RL12
	wire logic sw_ov = wr_exc ? REG_WDATA[EXC_OV_BIT] : ov;
	wire logic next_ov = ov_update ? res.overflow : sw_ov; // RL8
	// instructions never reach the carry bit; only software writes it
	wire logic next_ca = wr_exc ? REG_WDATA[EXC_CA_BIT] : ca; // RL9

	wire logic res_neg = res.value[DATA_W-1];
	wire logic res_zero = (res.value == WORD_ZERO);
	logic [COND_W-1:0] hw_cond;
	always_comb begin
		hw_cond = COND_RESET;
		hw_cond[COND_LT_BIT] = res_neg; // RL11
		hw_cond[COND_GT_BIT] = !res_neg && !res_zero; // RL11
		hw_cond[COND_EQ_BIT] = res_zero; // RL11
		hw_cond[COND_SO_BIT] = next_so; // RL11
	end
	wire logic [COND_W-1:0] sw_cond = wr_cond ?
		REG_WDATA[COND_W-1:0] : cond;
	wire logic [COND_W-1:0] next_cond = cond_update ?
		hw_cond : sw_cond; // RL10

	// sticky interrupt events, write one to clear, set wins
	logic [INT_W-1:0] events;
	always_comb begin
		events = INT_RESET;
		events[INT_OVF_BIT] = so_set;
		events[INT_ILLEGAL_BIT] = ISSUE_VALID && dec.illegal;
		events[INT_ZEROED_BIT] = executes && res.zeroed;
	end
	wire logic [INT_W-1:0] clear_bits = wr_int_status ?
		REG_WDATA[INT_W-1:0] : INT_RESET;
	wire logic [INT_W-1:0] next_int_status =
		(int_status & ~clear_bits) | events;
	wire logic [INT_W-1:0] next_int_mask = wr_int_mask ?
		REG_WDATA[INT_W-1:0] : int_mask;
	wire logic next_irq = |(next_int_status & next_int_mask);

	wire logic [COUNT_W-1:0] next_op_count = executes ?
		op_count + {{(COUNT_W-1){1'b0}}, 1'b1} : op_count;

	// a cast, since the default width leaves no padding to replicate
	wire logic [DATA_W-1:0] count_word = DATA_W'(op_count);
	wire logic [DATA_W-1:0] cond_word =
		{{(DATA_W-COND_W){1'b0}}, cond};
	wire logic [DATA_W-1:0] int_status_word =
		{{(DATA_W-INT_W){1'b0}}, int_status};
	wire logic [DATA_W-1:0] int_mask_word =
		{{(DATA_W-INT_W){1'b0}}, int_mask};
	// unmapped addresses read as zero
	wire logic [DATA_W-1:0] read_word =
		(REG_ADDR == ADDR_EXC) ? exc_pack(so, ov, ca) :
		(REG_ADDR == ADDR_COND) ? cond_word :
		(REG_ADDR == ADDR_RESULT) ? last_result :
		(REG_ADDR == ADDR_INT_STATUS) ? int_status_word :
		(REG_ADDR == ADDR_INT_MASK) ? int_mask_word :
		(REG_ADDR == ADDR_OP_COUNT) ? count_word : WORD_ZERO;

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			WB_VALID <= 1'b0;
			WB_INDEX <= '0;
			WB_DATA <= WORD_ZERO;
			last_result <= WORD_ZERO;
		end else begin
			WB_VALID <= executes; // RL3 RL5
			if (executes) begin
				WB_INDEX <= dec.target_reg_index;
				WB_DATA <= res.value;
				last_result <= res.value;
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			so <= 1'b0;
			ov <= 1'b0;
			ca <= 1'b0;
			cond <= COND_RESET;
			SUMMARY_OVERFLOW <= 1'b0;
			OVERFLOW <= 1'b0;
			CARRY <= 1'b0;
			COND_FIELD0 <= COND_RESET;
		end else begin
			so <= next_so;
			ov <= next_ov;
			ca <= next_ca;
			cond <= next_cond;
			SUMMARY_OVERFLOW <= next_so;
			OVERFLOW <= next_ov;
			CARRY <= next_ca;
			COND_FIELD0 <= next_cond;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			int_status <= INT_RESET;
			int_mask <= INT_RESET;
			IRQ <= 1'b0;
			op_count <= '0;
			REG_RDATA <= WORD_ZERO;
		end else begin
			int_status <= next_int_status;
			int_mask <= next_int_mask;
			IRQ <= next_irq;
			op_count <= next_op_count;
			// read data stand only in the cycle after the strobe
			REG_RDATA <= REG_RD ? read_word : WORD_ZERO;
		end
	end
endmodule

// ==== alu_props.sv ====
`timescale 1ns/10ps
module alu_props import doz_pkg::*; (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic ISSUE_VALID,
	input wire logic [DATA_W-1:0] ISSUE_INSTR,
	input wire logic [DATA_W-1:0] FIRST_SRC_DATA,
	input wire logic [DATA_W-1:0] SECOND_SRC_DATA,
	input wire logic WB_VALID,
	input wire logic [DATA_W-1:0] WB_DATA,
	input wire logic SUMMARY_OVERFLOW,
	input wire logic OVERFLOW,
	input wire logic CARRY,
	input wire logic [COND_W-1:0] COND_FIELD0,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic REG_WR
);
	wire [5:0] opc = ISSUE_INSTR[OPC_HI:OPC_LO];
	wire reg_op = ISSUE_VALID && opc == OPC_REG_FORM
		&& ISSUE_INSTR[XO_HI:XO_LO] == XO_DOZ;
	wire imm_op = ISSUE_VALID && opc == OPC_IMM_FORM;
	wire [15:0] si = ISSUE_INSTR[SI_HI:SI_LO];
	wire [31:0] b_op = reg_op ? SECOND_SRC_DATA : {{16{si[15]}}, si};
	wire gt = $signed(FIRST_SRC_DATA) > $signed(b_op);
	wire [31:0] exp_w = gt ? 32'h0 : b_op - FIRST_SRC_DATA;
	// operands already ordered, so bit 31 set means positive overflow
	wire ovf = !gt && exp_w[31];
	wire [2:0] sgn = {exp_w[31], !exp_w[31] && exp_w != 0, exp_w == 0};
	wire oe = reg_op && ISSUE_INSTR[OE_POS];
	wire rc = reg_op && ISSUE_INSTR[RC_POS];
	wire exc_wr = REG_WR && REG_ADDR == ADDR_EXC;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	sequence reg_issue_s; reg_op; endsequence
	sequence wb_s; WB_VALID; endsequence
	reg_diff_a: assert property (reg_issue_s |=>
		wb_s ##0 WB_DATA == $past(exp_w)) else $error("reg result wrong");
	imm_diff_a: assert property (imm_op |=>
		wb_s ##0 WB_DATA == $past(exp_w)) else $error("imm result wrong");
	refuse_op_a: assert property (ISSUE_VALID && !reg_op && !imm_op
		|=> !WB_VALID) else $error("unknown op written back");
	ovf_update_a: assert property (oe |=> OVERFLOW == $past(ovf)
		&& (SUMMARY_OVERFLOW || !$past(ovf))) else $error("overflow wrong");
	flags_hold_a: assert property (ISSUE_VALID && !oe && !REG_WR
		|=> $stable(OVERFLOW) && $stable(SUMMARY_OVERFLOW))
		else $error("exception bits moved");
	carry_keep_a: assert property (!exc_wr |=> $stable(CARRY))
		else $error("carry moved");
	so_sticky_a: assert property (SUMMARY_OVERFLOW && !exc_wr
		|=> SUMMARY_OVERFLOW) else $error("summary dropped");
	cond_rec_a: assert property (rc |=>
		COND_FIELD0 == {$past(sgn), SUMMARY_OVERFLOW})
		else $error("condition field wrong");
	cond_hold_a: assert property (ISSUE_VALID && !rc && !REG_WR
		|=> $stable(COND_FIELD0)) else $error("condition field moved");
endmodule
bind difference_or_zero_alu alu_props u_props (.REF_CLK, .RST_N,
	.ISSUE_VALID, .ISSUE_INSTR, .FIRST_SRC_DATA, .SECOND_SRC_DATA,
	.WB_VALID, .WB_DATA, .SUMMARY_OVERFLOW, .OVERFLOW, .CARRY,
	.COND_FIELD0, .REG_ADDR, .REG_WR);

// ==== issue_source.sv ====
`timescale 1ns/10ps
module issue_source (
	input wire logic clk,
	input wire logic req_valid,
	input wire logic [31:0] req_instr,
	input wire logic wb_valid,
	input wire logic [4:0] wb_index,
	input wire logic [31:0] wb_data,
	output logic [31:0] first_data,
	output logic [31:0] second_data
);
	logic [31:0] regs [32];
	wire [31:0] a_val = regs[req_instr[20:16]];
	wire [31:0] b_val = regs[req_instr[15:11]];
	// complemented operands outside an issue, never a held copy
	assign first_data = req_valid ? a_val : ~a_val;
	assign second_data = req_valid ? b_val : ~b_val;
	always @(posedge clk) begin
		if (wb_valid) begin
			regs[wb_index] <= wb_data;
		end
	end
endmodule

// ==== difference_or_zero_alu_bench.sv ====
`timescale 1ns/10ps
module difference_or_zero_alu_bench;
	import doz_pkg::*;
	typedef struct packed {
		logic [31:0] ins;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] res;
	} row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rv = 1'b0;
	logic [31:0] ri = 32'h0;
	logic [7:0] addr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	wire wbv, so, ov, ca, irq;
	wire [31:0] fa, sb, wbd, rdata;
	wire [4:0] wbi;
	wire [3:0] cond;
	int bad_count = 0;
	int checks_done = 0;
	row_t rows [9];
	always #5 clk = ~clk;
	issue_source src (.clk(clk), .req_valid(rv), .req_instr(ri),
		.wb_valid(wbv), .wb_index(wbi), .wb_data(wbd),
		.first_data(fa), .second_data(sb));
	difference_or_zero_alu dut (.REF_CLK(clk), .RST_N(rst_n),
		.ISSUE_VALID(rv), .ISSUE_INSTR(ri), .FIRST_SRC_DATA(fa),
		.SECOND_SRC_DATA(sb), .WB_VALID(wbv), .WB_INDEX(wbi), .WB_DATA(wbd),
		.SUMMARY_OVERFLOW(so), .OVERFLOW(ov), .CARRY(ca), .COND_FIELD0(cond),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
		.REG_RDATA(rdata), .IRQ(irq));
	function automatic logic [31:0] rf(input logic oe, input logic rc);
		return {OPC_REG_FORM, 5'h3, 5'h1, 5'h2, oe, XO_DOZ, rc};
	endfunction
	function automatic logic [31:0] imf(input logic [15:0] si);
		return {OPC_IMM_FORM, 5'h3, 5'h1, si};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic issue(input logic [31:0] ins, input logic [31:0] a,
		input logic [31:0] b);
		@(posedge clk);
		src.regs[1] <= a;
		src.regs[2] <= b;
		rv <= 1'b1;
		ri <= ins;
		@(posedge clk);
		rv <= 1'b0;
		#1;
	endtask
	// one strobe per call, so a gap cycle separates calls
	task automatic bus(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		@(posedge clk);
		addr <= ad;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
	endtask
	initial begin
		rows[0] = '{rf(1'b1, 1'b1), 32'h2, 32'h8, 32'h6};
		rows[1] = '{rf(1'b0, 1'b0), 32'h1, 32'h2, 32'h1};
		rows[2] = '{rf(1'b0, 1'b1), 32'h1, 32'h0, 32'h0};
		rows[3] = '{rf(1'b1, 1'b1), 32'hefffffff, 32'h0, 32'h10000001};
		rows[4] = '{rf(1'b0, 1'b0), 32'hffffffff, 32'h5, 32'h6};
		rows[5] = '{rf(1'b1, 1'b0), 32'h80000000, 32'h7fffffff, 32'hffffffff};
		rows[6] = '{imf(16'h0), 32'h1, 32'h0, 32'h0};
		rows[7] = '{imf(16'hfff8), 32'hfffffff0, 32'h0, 32'h8};
		rows[8] = '{imf(16'h8000), 32'h5, 32'h0, 32'h0};
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk({so, ov, ca, irq, wbv, cond}, 32'h0);
		chk(wbd, 32'h0);
		chk(rdata, 32'h0);
		$display("reset done");
		bus(1'b1, ADDR_INT_MASK, 32'h1);
		foreach (rows[i]) begin
			issue(rows[i].ins, rows[i].a, rows[i].b);
			chk(wbv, 1'b1);
			chk(wbi, 32'h3);
			chk(wbd, rows[i].res);
		end
		chk(ov, 1'b1);
		chk(irq, 1'b1);
		bus(1'b0, ADDR_INT_STATUS, 32'h0);
		chk(rdata, 32'h5);
		bus(1'b1, ADDR_INT_STATUS, 32'h1);
		chk(irq, 1'b0);
		bus(1'b0, ADDR_EXC, 32'h0);
		chk(rdata, 32'hc0000000);
		$display("table and interrupt done");
		issue(rf(1'b1, 1'b0), 32'h2, 32'h8);
		chk({ov, so}, 32'h1);
		bus(1'b1, ADDR_EXC, 32'h20000000);
		chk({so, ca}, 32'h1);
		issue(rf(1'b1, 1'b1), 32'h80000000, 32'h7fffffff);
		chk(ca, 1'b1);
		chk(cond, 32'h9);
		// right primary opcode, neighbouring extended opcode
		issue({OPC_REG_FORM, 5'h3, 5'h1, 5'h2, 1'b0, 9'h109, 1'b0},
			32'h1, 32'h4);
		chk(wbv, 1'b0);
		bus(1'b0, ADDR_INT_STATUS, 32'h0);
		chk(rdata, 32'h7);
		bus(1'b0, 8'hfc, 32'h0);
		chk(rdata, 32'h0);
		$display("flags and refusal done");
		@(posedge clk);
		rv <= 1'b1;
		ri <= imf(16'h9);
		@(posedge clk);
		ri <= rf(1'b0, 1'b0);
		#1 chk(wbd, 32'h8);
		@(posedge clk);
		rv <= 1'b0;
		#1 chk(wbv, 1'b1);
		chk(wbd, 32'h3);
		bus(1'b0, ADDR_RESULT, 32'h0);
		chk(rdata, 32'h3);
		@(posedge clk);
		#1 chk(rdata, 32'h0);
		bus(1'b0, ADDR_OP_COUNT, 32'h0);
		chk(rdata, 32'hd);
		bus(1'b1, ADDR_COND, 32'ha);
		chk(cond, 32'ha);
		bus(1'b0, ADDR_COND, 32'h0);
		chk(rdata, 32'ha);
		$display("back to back done");
		// flags, interrupt and count are all set before this reset
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk({so, ov, ca, irq, wbv, cond}, 32'h0);
		chk(wbd, 32'h0);
		issue(rf(1'b0, 1'b1), 32'h3, 32'h3);
		chk(wbd, 32'h0);
		chk(cond, 32'h2);
		bus(1'b0, ADDR_OP_COUNT, 32'h0);
		chk(rdata, 32'h1);
		$display("second reset done");
		close_out();
	end
endmodule
